// ===== hw/tmf_pkg.sv
package tmf_pkg;
  localparam logic [7:0] SHARED_FLAGS_IO = 8'h36;
  localparam logic [7:0] IO_TO_DATA_OFFSET = 8'h20;
  localparam logic [7:0] SHARED_FLAGS_DATA = 8'h56;
  localparam logic [7:0] SHARED_MASK_IO = 8'h37;
  localparam logic [7:0] SHARED_MASK_DATA = 8'h57;
  localparam logic [7:0] EXT_FLAGS_DATA = 8'h7c;
  localparam logic [7:0] EXT_MASK_DATA = 8'h7d;
  localparam logic [7:0] IO_SPACE_LAST = 8'h3f;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Shared register bit positions
  localparam int U1_CAPTURE_BIT = 5;
  localparam int U1_CMP_A_BIT = 4;
  localparam int U1_CMP_B_BIT = 3;
  localparam int U1_OVERFLOW_BIT = 2;
  localparam logic [7:0] SHARED_U1_BITS = 8'h3c;
  // Extended register bit positions
  localparam int U3_CAPTURE_BIT = 5;
  localparam int U3_CMP_A_BIT = 4;
  localparam int U3_CMP_B_BIT = 3;
  localparam int U3_OVERFLOW_BIT = 2;
  localparam int U3_CMP_C_BIT = 1;
  localparam int U1_CMP_C_BIT = 0;
  localparam logic [7:0] EXT_USED_BITS = 8'h3f;
  // Waveform generation modes with overflow at MAX/TOP wrap
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_CLR_CMP = 4'h4;
  localparam logic [3:0] WGM_CLR_CAP = 4'hc;

  // Events of one 16-bit timer unit, in timer clock terms
  typedef struct packed {
    logic tick;
    logic capture_edge;
    logic capture_is_top;
    logic at_top;
    logic at_bottom;
    logic overflow;
    logic [3:0] wgm;
    logic match_a;
    logic match_b;
    logic match_c;
    logic force_a;
    logic force_b;
    logic force_c;
  } tmf_unit_ev_t;

  // Flags of one unit, capture/a/b/overflow/c
  typedef struct packed {
    logic capture;
    logic cmp_a;
    logic cmp_b;
    logic overflow;
    logic cmp_c;
  } tmf_unit_set_t;

  // CPU access port
  typedef struct packed {
    logic io_en;
    logic data_en;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tmf_cpu_req_t;
endpackage

// ===== hw/tmf_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module tmf_sync2 #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// ===== hw/tmf_unit_events.sv
`timescale 1ns/1ps
`default_nettype none
module tmf_unit_events (
  input wire logic clk,
  input wire logic rst_n,
  input wire tmf_pkg::tmf_unit_ev_t ev,
  input wire logic cap_pin_sync,
  output tmf_pkg::tmf_unit_set_t set
);
  logic cap_prev;
  logic pending_a;
  logic pending_b;
  logic pending_c;
  logic ovf_by_mode;

  // Edge of the already synchronised capture pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_prev <= 1'b0;
    end else begin
      cap_prev <= cap_pin_sync;
    end
  end

  // Match latched, flag raised on the next timer tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_a <= 1'b0;
      pending_b <= 1'b0;
      pending_c <= 1'b0;
    end else if (ev.tick) begin
      pending_a <= ev.match_a && !ev.force_a;
      pending_b <= ev.match_b && !ev.force_b;
      pending_c <= ev.match_c && !ev.force_c;
    end
  end

  always_comb begin
    unique case (ev.wgm)
      tmf_pkg::WGM_NORMAL, tmf_pkg::WGM_CLR_CMP, tmf_pkg::WGM_CLR_CAP: begin
        ovf_by_mode = ev.overflow;
      end
      default: begin
        // PWM modes: overflow strobe from the counter's own mode logic
        ovf_by_mode = ev.overflow || (ev.at_bottom && ev.at_top);
      end
    endcase
  end

  always_comb begin
    set.capture = (cap_pin_sync && !cap_prev && !ev.capture_is_top) ||
                  (ev.tick && ev.capture_is_top && ev.at_top);
    set.cmp_a = ev.tick && pending_a;
    set.cmp_b = ev.tick && pending_b;
    set.cmp_c = ev.tick && pending_c;
    set.overflow = ev.tick && ovf_by_mode;
  end
endmodule
`default_nettype wire

// ===== hw/tmf_irq_flags.sv
`timescale 1ns/1ps
`default_nettype none
module tmf_irq_flags (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // Configuration
  input wire logic LEGACY_MODE,
  input wire logic GLOBAL_IRQ_EN,
  // Shared mask bits held outside this block
  input wire logic [7:0] SHARED_MASK,
  // CPU access
  input wire tmf_pkg::tmf_cpu_req_t CPU_REQ,
  output logic [7:0] CPU_RDATA,
  output logic CPU_RVALID,
  // Vector execution acknowledges, one per flag
  input wire tmf_pkg::tmf_unit_set_t U1_VECTOR_ACK,
  input wire tmf_pkg::tmf_unit_set_t U3_VECTOR_ACK,
  // Timer unit events
  input wire tmf_pkg::tmf_unit_ev_t U1_EV,
  input wire tmf_pkg::tmf_unit_ev_t U3_EV,
  // Capture pins
  input wire logic U1_CAPTURE_PIN,
  input wire logic U3_CAPTURE_PIN,
  // Interrupt requests, capture/a/b/overflow/c
  output tmf_pkg::tmf_unit_set_t U1_IRQ,
  output tmf_pkg::tmf_unit_set_t U3_IRQ,
  // Flag images
  output logic [7:0] SHARED_FLAGS,
  output logic [7:0] EXT_FLAGS
);
  logic [1:0] pin_sync;
  tmf_pkg::tmf_unit_set_t u1_set;
  tmf_pkg::tmf_unit_set_t u3_set;
  logic [7:0] shared_flags;
  logic [7:0] ext_flags;
  logic [7:0] ext_mask;
  logic shared_hit;
  logic ext_flags_hit;
  logic ext_mask_hit;
  logic [7:0] shared_w1c;
  logic [7:0] ext_w1c;
  logic [7:0] shared_set;
  logic [7:0] ext_set;
  logic [7:0] shared_ack;
  logic [7:0] ext_ack;
  logic [7:0] next_shared_flags;
  logic [7:0] next_ext_flags;
  logic [7:0] next_rdata;

  tmf_sync2 #(
    .WIDTH(2)
  ) u_pin_sync (
    .clk(REF_CLK),
    .rst_n(RESET_N),
    .async_in({U3_CAPTURE_PIN, U1_CAPTURE_PIN}),
    .sync_out(pin_sync)
  );

  tmf_unit_events u_unit1 (
    .clk(REF_CLK),
    .rst_n(RESET_N),
    .ev(U1_EV),
    .cap_pin_sync(pin_sync[0]),
    .set(u1_set)
  );

  tmf_unit_events u_unit3 (
    .clk(REF_CLK),
    .rst_n(RESET_N),
    .ev(U3_EV),
    .cap_pin_sync(pin_sync[1]),
    .set(u3_set)
  );

  // Address decode
  always_comb begin
    shared_hit = (CPU_REQ.io_en && CPU_REQ.addr == tmf_pkg::SHARED_FLAGS_IO) ||
                 (CPU_REQ.data_en && CPU_REQ.addr == tmf_pkg::SHARED_FLAGS_DATA);
    // Extended space only through data-space access
    ext_flags_hit = CPU_REQ.data_en && !LEGACY_MODE &&
                    CPU_REQ.addr == tmf_pkg::EXT_FLAGS_DATA;
    ext_mask_hit = CPU_REQ.data_en && !LEGACY_MODE &&
                   CPU_REQ.addr == tmf_pkg::EXT_MASK_DATA;
  end

  // Hardware set sources placed at register positions
  always_comb begin
    shared_set = tmf_pkg::REG_RESET;
    shared_set[tmf_pkg::U1_CAPTURE_BIT] = u1_set.capture;
    shared_set[tmf_pkg::U1_CMP_A_BIT] = u1_set.cmp_a;
    shared_set[tmf_pkg::U1_CMP_B_BIT] = u1_set.cmp_b;
    shared_set[tmf_pkg::U1_OVERFLOW_BIT] = u1_set.overflow;
    ext_set = tmf_pkg::REG_RESET;
    ext_set[tmf_pkg::U3_CAPTURE_BIT] = u3_set.capture;
    ext_set[tmf_pkg::U3_CMP_A_BIT] = u3_set.cmp_a;
    ext_set[tmf_pkg::U3_CMP_B_BIT] = u3_set.cmp_b;
    ext_set[tmf_pkg::U3_OVERFLOW_BIT] = u3_set.overflow;
    ext_set[tmf_pkg::U3_CMP_C_BIT] = u3_set.cmp_c;
    ext_set[tmf_pkg::U1_CMP_C_BIT] = u1_set.cmp_c;
  end

  // Vector execution clears
  always_comb begin
    shared_ack = tmf_pkg::REG_RESET;
    shared_ack[tmf_pkg::U1_CAPTURE_BIT] = U1_VECTOR_ACK.capture;
    shared_ack[tmf_pkg::U1_CMP_A_BIT] = U1_VECTOR_ACK.cmp_a;
    shared_ack[tmf_pkg::U1_CMP_B_BIT] = U1_VECTOR_ACK.cmp_b;
    shared_ack[tmf_pkg::U1_OVERFLOW_BIT] = U1_VECTOR_ACK.overflow;
    ext_ack = tmf_pkg::REG_RESET;
    ext_ack[tmf_pkg::U3_CAPTURE_BIT] = U3_VECTOR_ACK.capture;
    ext_ack[tmf_pkg::U3_CMP_A_BIT] = U3_VECTOR_ACK.cmp_a;
    ext_ack[tmf_pkg::U3_CMP_B_BIT] = U3_VECTOR_ACK.cmp_b;
    ext_ack[tmf_pkg::U3_OVERFLOW_BIT] = U3_VECTOR_ACK.overflow;
    ext_ack[tmf_pkg::U3_CMP_C_BIT] = U3_VECTOR_ACK.cmp_c;
    ext_ack[tmf_pkg::U1_CMP_C_BIT] = U1_VECTOR_ACK.cmp_c;
  end

  // One-writes clear; zero bits leave the flag alone
  always_comb begin
    shared_w1c = (CPU_REQ.wr && shared_hit) ? CPU_REQ.wdata : tmf_pkg::REG_RESET;
    ext_w1c = (CPU_REQ.wr && ext_flags_hit) ? CPU_REQ.wdata : tmf_pkg::REG_RESET;
  end

  // Set wins over any clear in the same cycle
  always_comb begin
    next_shared_flags = ((shared_flags & ~(shared_w1c | shared_ack)) | shared_set) &
                        tmf_pkg::SHARED_U1_BITS;
    next_ext_flags = ((ext_flags & ~(ext_w1c | ext_ack)) | ext_set) &
                     tmf_pkg::EXT_USED_BITS;
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      shared_flags <= tmf_pkg::REG_RESET;
    end else begin
      shared_flags <= next_shared_flags;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ext_flags <= tmf_pkg::REG_RESET;
    end else begin
      ext_flags <= next_ext_flags;
    end
  end

  // Extended mask register
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ext_mask <= tmf_pkg::REG_RESET;
    end else if (LEGACY_MODE) begin
      ext_mask <= tmf_pkg::REG_RESET;
    end else if (CPU_REQ.wr && ext_mask_hit) begin
      ext_mask <= CPU_REQ.wdata & tmf_pkg::EXT_USED_BITS;
    end
  end

  // Read data, one cycle after the request
  always_comb begin
    next_rdata = tmf_pkg::REG_RESET;
    if (shared_hit) begin
      next_rdata = shared_flags;
    end else if (ext_flags_hit) begin
      next_rdata = ext_flags;
    end else if (ext_mask_hit) begin
      next_rdata = ext_mask;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CPU_RDATA <= tmf_pkg::REG_RESET;
      CPU_RVALID <= 1'b0;
    end else begin
      CPU_RDATA <= next_rdata;
      CPU_RVALID <= CPU_REQ.rd && (shared_hit || ext_flags_hit || ext_mask_hit);
    end
  end

  // Interrupt requests gated by mask and global enable
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      U1_IRQ <= '0;
      U3_IRQ <= '0;
    end else begin
      U1_IRQ.capture <= GLOBAL_IRQ_EN && SHARED_MASK[tmf_pkg::U1_CAPTURE_BIT] &&
                        next_shared_flags[tmf_pkg::U1_CAPTURE_BIT];
      U1_IRQ.cmp_a <= GLOBAL_IRQ_EN && SHARED_MASK[tmf_pkg::U1_CMP_A_BIT] &&
                      next_shared_flags[tmf_pkg::U1_CMP_A_BIT];
      U1_IRQ.cmp_b <= GLOBAL_IRQ_EN && SHARED_MASK[tmf_pkg::U1_CMP_B_BIT] &&
                      next_shared_flags[tmf_pkg::U1_CMP_B_BIT];
      U1_IRQ.overflow <= GLOBAL_IRQ_EN && SHARED_MASK[tmf_pkg::U1_OVERFLOW_BIT] &&
                         next_shared_flags[tmf_pkg::U1_OVERFLOW_BIT];
      U1_IRQ.cmp_c <= GLOBAL_IRQ_EN && !LEGACY_MODE && ext_mask[tmf_pkg::U1_CMP_C_BIT] &&
                      next_ext_flags[tmf_pkg::U1_CMP_C_BIT];
      U3_IRQ.capture <= GLOBAL_IRQ_EN && !LEGACY_MODE && ext_mask[tmf_pkg::U3_CAPTURE_BIT] &&
                        next_ext_flags[tmf_pkg::U3_CAPTURE_BIT];
      U3_IRQ.cmp_a <= GLOBAL_IRQ_EN && !LEGACY_MODE && ext_mask[tmf_pkg::U3_CMP_A_BIT] &&
                      next_ext_flags[tmf_pkg::U3_CMP_A_BIT];
      U3_IRQ.cmp_b <= GLOBAL_IRQ_EN && !LEGACY_MODE && ext_mask[tmf_pkg::U3_CMP_B_BIT] &&
                      next_ext_flags[tmf_pkg::U3_CMP_B_BIT];
      U3_IRQ.overflow <= GLOBAL_IRQ_EN && !LEGACY_MODE && ext_mask[tmf_pkg::U3_OVERFLOW_BIT] &&
                         next_ext_flags[tmf_pkg::U3_OVERFLOW_BIT];
      U3_IRQ.cmp_c <= GLOBAL_IRQ_EN && !LEGACY_MODE && ext_mask[tmf_pkg::U3_CMP_C_BIT] &&
                      next_ext_flags[tmf_pkg::U3_CMP_C_BIT];
    end
  end

  // Flag images
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SHARED_FLAGS <= tmf_pkg::REG_RESET;
      EXT_FLAGS <= tmf_pkg::REG_RESET;
    end else begin
      SHARED_FLAGS <= next_shared_flags;
      EXT_FLAGS <= next_ext_flags;
    end
  end
endmodule
`default_nettype wire

// ===== verification/tmf_irq_flags_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tmf_irq_flags_asserts (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // Configuration
  input wire logic LEGACY_MODE,
  input wire logic GLOBAL_IRQ_EN,
  input wire logic [7:0] SHARED_MASK,
  // CPU access
  input wire tmf_pkg::tmf_cpu_req_t CPU_REQ,
  input wire logic [7:0] CPU_RDATA,
  input wire logic CPU_RVALID,
  // Vector acks and events
  input wire tmf_pkg::tmf_unit_set_t U1_VECTOR_ACK,
  input wire tmf_pkg::tmf_unit_set_t U3_VECTOR_ACK,
  input wire tmf_pkg::tmf_unit_ev_t U1_EV,
  input wire tmf_pkg::tmf_unit_ev_t U3_EV,
  input wire logic U1_CAPTURE_PIN,
  input wire logic U3_CAPTURE_PIN,
  // Outputs watched
  input wire tmf_pkg::tmf_unit_set_t U1_IRQ,
  input wire tmf_pkg::tmf_unit_set_t U3_IRQ,
  input wire logic [7:0] SHARED_FLAGS,
  input wire logic [7:0] EXT_FLAGS
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  logic shr_wr;
  assign shr_wr = CPU_REQ.wr && ((CPU_REQ.io_en && CPU_REQ.addr == 8'h36) ||
    (CPU_REQ.data_en && CPU_REQ.addr == 8'h56));
  a_u1_ovf_irq: assert property (
    (SHARED_MASK[2] && GLOBAL_IRQ_EN && SHARED_FLAGS[2]) [*2] |-> U1_IRQ.overflow)
    else $error("overflow request missing");
  a_irq_needs_global: assert property (
    !GLOBAL_IRQ_EN [*2] |-> U1_IRQ == 5'h00 && U3_IRQ == 5'h00) else $error("request without global");
  a_legacy_no_ext: assert property (
    LEGACY_MODE [*2] |-> U3_IRQ == 5'h00 && !U1_IRQ.cmp_c) else $error("extended request in legacy");
  a_match_sets_flag: assert property (
    U3_EV.tick && U3_EV.match_a && !U3_EV.force_a |-> ##[1:3] EXT_FLAGS[4])
    else $error("compare flag not set");
  a_force_stays_quiet: assert property (
    U1_EV.force_b && !$past(U1_EV.match_b) && !SHARED_FLAGS[3] |=> !SHARED_FLAGS[3] [*3])
    else $error("forced compare set flag");
  a_one_write_clears: assert property (
    shr_wr && CPU_REQ.wdata[2] && !U1_EV.overflow |=> !SHARED_FLAGS[2]) else $error("flag not cleared");
  a_zero_write_keeps: assert property (
    shr_wr && !CPU_REQ.wdata[2] && SHARED_FLAGS[2] && !U1_VECTOR_ACK.overflow |=> SHARED_FLAGS[2])
    else $error("zero write cleared flag");
  a_ack_clears_ext: assert property (
    U3_VECTOR_ACK.cmp_a && !U3_EV.match_a && !$past(U3_EV.match_a) |=> !EXT_FLAGS[4])
    else $error("ack left flag");
  a_ext_read_answers: assert property (
    CPU_REQ.rd && CPU_REQ.data_en && CPU_REQ.addr == 8'h7c && !LEGACY_MODE |=> CPU_RVALID)
    else $error("read not answered");
  a_io_ext_ignored: assert property (
    CPU_REQ.rd && CPU_REQ.io_en && !CPU_REQ.data_en && CPU_REQ.addr == 8'h7d |=> !CPU_RVALID)
    else $error("short access reached extended register");
  a_ext_top_unused: assert property (EXT_FLAGS[7:6] == 2'b00) else $error("unused bits set");
  c_u1_irq: cover property (U1_IRQ.overflow);
  c_u3_irq: cover property (U3_IRQ.cmp_a);
  c_legacy: cover property (LEGACY_MODE && CPU_REQ.wr);
endmodule
bind tmf_irq_flags tmf_irq_flags_asserts u_chk (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
  .LEGACY_MODE(LEGACY_MODE), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .SHARED_MASK(SHARED_MASK),
  .CPU_REQ(CPU_REQ), .CPU_RDATA(CPU_RDATA), .CPU_RVALID(CPU_RVALID),
  .U1_VECTOR_ACK(U1_VECTOR_ACK), .U3_VECTOR_ACK(U3_VECTOR_ACK), .U1_EV(U1_EV), .U3_EV(U3_EV),
  .U1_CAPTURE_PIN(U1_CAPTURE_PIN), .U3_CAPTURE_PIN(U3_CAPTURE_PIN), .U1_IRQ(U1_IRQ),
  .U3_IRQ(U3_IRQ), .SHARED_FLAGS(SHARED_FLAGS), .EXT_FLAGS(EXT_FLAGS));
`default_nettype wire

// ===== verification/tmf_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module tmf_cpu_model (
  // Clock
  input wire logic clk,
  // Access port
  output tmf_pkg::tmf_cpu_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  initial req = '0;
  // One byte access, request held for exactly one edge
  task automatic access(input logic io, input logic wr, input logic [7:0] addr,
    input logic [7:0] wd, output logic [7:0] rd, output logic ok);
    @(posedge clk);
    req <= '{io_en: io, data_en: !io, wr: wr, rd: !wr, addr: addr, wdata: wd};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    rd = rdata;
    ok = rvalid;
  endtask
endmodule
`default_nettype wire

// ===== verification/tmf_irq_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tmf_irq_flags_tb;
  localparam tmf_pkg::tmf_unit_ev_t IDLE = 16'h8000;
  logic REF_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic LEGACY_MODE = 1'b0;
  logic GLOBAL_IRQ_EN = 1'b0;
  logic [7:0] SHARED_MASK = 8'h00;
  logic U1_CAPTURE_PIN = 1'b0;
  logic U3_CAPTURE_PIN = 1'b0;
  tmf_pkg::tmf_unit_set_t U1_VECTOR_ACK = '0;
  tmf_pkg::tmf_unit_set_t U3_VECTOR_ACK = '0;
  tmf_pkg::tmf_unit_ev_t U1_EV = IDLE;
  tmf_pkg::tmf_unit_ev_t U3_EV = IDLE;
  tmf_pkg::tmf_cpu_req_t CPU_REQ;
  tmf_pkg::tmf_unit_set_t U1_IRQ, U3_IRQ;
  logic [7:0] CPU_RDATA, SHARED_FLAGS, EXT_FLAGS, rv;
  logic CPU_RVALID, ok;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  always #25 REF_CLK = ~REF_CLK;

  tmf_cpu_model cpu (.clk(REF_CLK), .req(CPU_REQ), .rdata(CPU_RDATA), .rvalid(CPU_RVALID));
  tmf_irq_flags dut (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .LEGACY_MODE(LEGACY_MODE),
    .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .SHARED_MASK(SHARED_MASK), .CPU_REQ(CPU_REQ),
    .CPU_RDATA(CPU_RDATA), .CPU_RVALID(CPU_RVALID), .U1_VECTOR_ACK(U1_VECTOR_ACK),
    .U3_VECTOR_ACK(U3_VECTOR_ACK), .U1_EV(U1_EV), .U3_EV(U3_EV),
    .U1_CAPTURE_PIN(U1_CAPTURE_PIN), .U3_CAPTURE_PIN(U3_CAPTURE_PIN), .U1_IRQ(U1_IRQ),
    .U3_IRQ(U3_IRQ), .SHARED_FLAGS(SHARED_FLAGS), .EXT_FLAGS(EXT_FLAGS));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] d);
    cpu.access(io, 1'b1, a, d, rv, ok);
  endtask

  task automatic rd(input logic io, input logic [7:0] a);
    cpu.access(io, 1'b0, a, 8'h00, rv, ok);
  endtask

  function automatic logic [7:0] bitm(input bit u3, input int k);
    if (k == 4) return u3 ? 8'h02 : 8'h01;
    return 8'h20 >> k;
  endfunction

  function automatic logic [7:0] img(input bit u3, input int k);
    return (!u3 && k < 4) ? SHARED_FLAGS : EXT_FLAGS;
  endfunction

  // Kinds: 0 capture at TOP, 1 cmp a, 2 cmp b, 3 overflow, 4 cmp c
  // A forced compare raises the match together with its strobe
  task automatic pulse(input bit u3, input int k, input bit frc);
    tmf_pkg::tmf_unit_ev_t e;
    e = IDLE;
    case (k)
      0: begin
        e.capture_is_top = 1'b1;
        e.at_top = 1'b1;
      end
      1: begin
        e.match_a = 1'b1;
        e.force_a = frc;
      end
      2: begin
        e.match_b = 1'b1;
        e.force_b = frc;
      end
      3: begin
        e.overflow = 1'b1;
        e.wgm = u3 ? tmf_pkg::WGM_CLR_CMP : tmf_pkg::WGM_NORMAL;
      end
      default: begin
        e.match_c = 1'b1;
        e.force_c = frc;
      end
    endcase
    @(posedge REF_CLK);
    if (u3) U3_EV <= e; else U1_EV <= e;
    @(posedge REF_CLK);
    U1_EV <= IDLE;
    U3_EV <= IDLE;
  endtask

  task automatic t_regs();
    rd(1'b0, 8'h7c);
    chk(rv, 8'h00);
    chk({7'h00, ok}, 8'h01);
    rd(1'b0, 8'h7d);
    chk(rv, 8'h00);
    rd(1'b1, 8'h36);
    chk(rv, 8'h00);
    rd(1'b0, 8'h56);
    chk(rv, 8'h00);
    wr(1'b0, 8'h7d, 8'hff);
    rd(1'b0, 8'h7d);
    chk(rv, 8'h3f);
    rd(1'b1, 8'h7d);
    chk({7'h00, ok}, 8'h00);
    rd(1'b0, 8'h7e);
    chk({7'h00, ok}, 8'h00);
    $display("registers test done");
  endtask

  task automatic t_flags();
    logic [7:0] m;
    logic [7:0] a;
    for (int u = 0; u < 2; u++) begin
      for (int k = 0; k < 5; k++) begin
        m = bitm(u[0], k);
        a = (u[0] || k == 4) ? 8'h7c : (k == 0 ? 8'h36 : 8'h56);
        pulse(u[0], k, 1'b0);
        for (int i = 0; i < 6 && (img(u[0], k) & m) == 8'h00; i++) @(posedge REF_CLK);
        chk(img(u[0], k), m);
        @(posedge REF_CLK);
        if (k % 2 == 1) begin
          if (u[0]) U3_VECTOR_ACK <= 5'h10 >> k; else U1_VECTOR_ACK <= 5'h10 >> k;
          @(posedge REF_CLK);
          U1_VECTOR_ACK <= '0;
          U3_VECTOR_ACK <= '0;
        end else begin
          wr(a == 8'h36, a, ~m);
          chk(img(u[0], k), m);
          wr(a == 8'h36, a, m);
        end
        repeat (2) @(posedge REF_CLK);
        chk(img(u[0], k), 8'h00);
      end
    end
    $display("flags test done");
  endtask

  task automatic t_force();
    for (int u = 0; u < 2; u++) begin
      for (int k = 1; k < 5; k += (k == 2) ? 2 : 1) begin
        pulse(u[0], k, 1'b1);
        repeat (4) @(posedge REF_CLK);
        chk(img(u[0], k), 8'h00);
      end
    end
    $display("forced compare test done");
  endtask

  task automatic t_pins();
    for (int u = 0; u < 2; u++) begin
      if (u == 1) U3_CAPTURE_PIN <= 1'b1; else U1_CAPTURE_PIN <= 1'b1;
      for (int i = 0; i < 8 && img(u[0], 0) == 8'h00; i++) @(posedge REF_CLK);
      chk(img(u[0], 0), 8'h20);
      U1_CAPTURE_PIN <= 1'b0;
      U3_CAPTURE_PIN <= 1'b0;
      wr(u == 0, u == 1 ? 8'h7c : 8'h36, 8'h20);
      chk(img(u[0], 0), 8'h00);
    end
    $display("capture pin test done");
  endtask

  // Overflow in the other counting modes follows the unit's own strobe
  task automatic t_modes();
    tmf_pkg::tmf_unit_ev_t e;
    for (int w = 0; w < 2; w++) begin
      e = IDLE;
      e.overflow = 1'b1;
      e.wgm = (w == 0) ? tmf_pkg::WGM_CLR_CAP : 4'h5;
      @(posedge REF_CLK);
      U3_EV <= e;
      @(posedge REF_CLK);
      U3_EV <= IDLE;
      repeat (2) @(posedge REF_CLK);
      chk(EXT_FLAGS, 8'h04);
      wr(1'b0, 8'h7c, 8'h04);
      chk(EXT_FLAGS, 8'h00);
    end
    $display("waveform mode test done");
  endtask

  task automatic t_irq();
    GLOBAL_IRQ_EN <= 1'b1;
    SHARED_MASK <= 8'h04;
    pulse(1'b1, 1, 1'b0);
    pulse(1'b0, 3, 1'b0);
    repeat (4) @(posedge REF_CLK);
    chk({3'h0, U3_IRQ}, 8'h08);
    chk({3'h0, U1_IRQ}, 8'h02);
    LEGACY_MODE <= 1'b1;
    wr(1'b0, 8'h7d, 8'h00);
    chk({3'h0, U3_IRQ}, 8'h00);
    LEGACY_MODE <= 1'b0;
    rd(1'b0, 8'h7d);
    chk(rv, 8'h00);
    GLOBAL_IRQ_EN <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    chk({3'h0, U1_IRQ | U3_IRQ}, 8'h00);
    wr(1'b0, 8'h56, 8'hfb);
    chk(SHARED_FLAGS, 8'h04);
    wr(1'b1, 8'h36, 8'hff);
    wr(1'b0, 8'h7c, 8'hff);
    chk(SHARED_FLAGS | EXT_FLAGS, 8'h00);
    $display("interrupt request test done");
  endtask

  initial begin
    repeat (6) @(posedge REF_CLK);
    RESET_N <= 1'b1;
    t_regs();
    t_flags();
    t_force();
    t_pins();
    t_modes();
    t_irq();
    report_and_stop();
  end
endmodule
`default_nettype wire
